// [logic/tenure_pkg.sv]
`default_nettype none
package tenure_pkg;

  // Register byte offsets.
  localparam logic [3:0] REG_MEMSUB_OFS = 4'h0;
  localparam logic [3:0] REG_CTRL_OFS   = 4'h4;
  localparam logic [3:0] REG_STAT_OFS   = 4'h8;

  // Field positions.
  localparam int MEMSUB_EXT_BIT    = 0;
  localparam int MEMSUB_DRIVEN_BIT = 1;
  localparam int CTRL_STREAM_BIT   = 0;
  localparam int STAT_BUSY_BIT     = 0;
  localparam int STAT_PEND_BIT     = 1;
  localparam int STAT_CNT_LSB      = 8;

  // Reset values.
  localparam logic CTRL_STREAM_RESET = 1'b1;

  // Transfer type codes.
  localparam logic [4:0] TYPE_READ_CLAIM   = 5'h0F;
  localparam logic [4:0] TYPE_LEGACY_TOUCH = 5'h0E;
  localparam logic [4:0] TYPE_READ         = 5'h0A;
  localparam logic [4:0] TYPE_WRITE        = 5'h02;

  // Transfer size codes, single beat and burst.
  localparam logic [2:0] SZ_8B      = 3'h0;
  localparam logic [2:0] SZ_1B      = 3'h1;
  localparam logic [2:0] SZ_2B      = 3'h2;
  localparam logic [2:0] SZ_3B      = 3'h3;
  localparam logic [2:0] SZ_4B      = 3'h4;
  localparam logic [2:0] BURST_2DW  = 3'h1;
  localparam logic [2:0] BURST_4DW  = 3'h2;

  // Byte lengths and highest start offsets in a double word.
  localparam logic [5:0] LEN_1B     = 6'h01;
  localparam logic [5:0] LEN_2B     = 6'h02;
  localparam logic [5:0] LEN_3B     = 6'h03;
  localparam logic [5:0] LEN_4B     = 6'h04;
  localparam logic [5:0] LEN_8B     = 6'h08;
  localparam logic [5:0] LEN_2DW    = 6'h10;
  localparam logic [5:0] LEN_4DW    = 6'h20;
  localparam logic [2:0] MAX_OFS_2B = 3'h6;
  localparam logic [2:0] MAX_OFS_3B = 3'h5;
  localparam logic [2:0] MAX_OFS_4B = 3'h4;

  // Strap capture phases after reset release.
  localparam logic [1:0] PHASE_MODE   = 2'h0;
  localparam logic [1:0] PHASE_DRIVEN = 2'h1;
  localparam logic [1:0] PHASE_DONE   = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_REQ    = 3'b010,
    ST_TENURE = 3'b100
  } tenure_state_t;

endpackage
`default_nettype wire

// [logic/size_encode.sv]
`timescale 1ns/10ps
`default_nettype none
module size_encode (
  input  wire logic       burst_in,
  input  wire logic       ext_mode_in,
  input  wire logic [5:0] len_in,
  input  wire logic [2:0] ofs_in,
  output logic      [2:0] size_out,
  output logic            legal_out
);

  always_comb begin
    size_out  = tenure_pkg::SZ_8B;
    legal_out = 1'b0;
    if (burst_in) begin
      if (len_in == tenure_pkg::LEN_4DW) begin
        size_out  = tenure_pkg::BURST_4DW;
        legal_out = (ofs_in == 3'h0);
      end else if (len_in == tenure_pkg::LEN_2DW) begin
        size_out  = tenure_pkg::BURST_2DW;
        legal_out = (ofs_in == 3'h0) && ext_mode_in;
      end
    end else begin
      case (len_in)
        tenure_pkg::LEN_1B: begin
          size_out  = tenure_pkg::SZ_1B;
          legal_out = 1'b1;
        end
        tenure_pkg::LEN_2B: begin
          size_out  = tenure_pkg::SZ_2B;
          legal_out = (ofs_in <= tenure_pkg::MAX_OFS_2B);
        end
        tenure_pkg::LEN_3B: begin
          size_out  = tenure_pkg::SZ_3B;
          legal_out = (ofs_in <= tenure_pkg::MAX_OFS_3B);
        end
        tenure_pkg::LEN_4B: begin
          size_out  = tenure_pkg::SZ_4B;
          legal_out = (ofs_in <= tenure_pkg::MAX_OFS_4B);
        end
        tenure_pkg::LEN_8B: begin
          size_out  = tenure_pkg::SZ_8B;
          legal_out = (ofs_in == 3'h0);
        end
        default: begin
          size_out  = tenure_pkg::SZ_8B;
          legal_out = 1'b0;
        end
      endcase
    end
  end

endmodule // size_encode
`default_nettype wire

// [logic/split_bus_address_tenure.sv]
// Operation
// - Without parked grant, raise bus request and wait for grant, same cycle or later.
// - With parked qualified grant, start the tenure at once without requesting.
// - Parked grant lets one master start a tenure every other cycle; here only in extended mode with streaming on, else every third.
// - Strap seen after reset release selects address-driven mode, else normal drive.
// - Address-driven mode reads back as a read-only bit of the MEMSUB register.
// - Address-driven mode only exists in extended bus mode.
// - Back-to-back tenures with no dead cycle, two cycles each when streaming.
// - Address parity generated in extended mode exactly as in legacy mode.
// - Tenures are split; data may return out of order.
// - In extended mode, sample cache-inhibit and write-through on global snoops to flag illegal intervention.
// - Touch-for-store bursts use read-claim type 01111, legacy uses 01110.
// - Read claim gives exclusive line ownership without marking it modified.
// - Burst size 001 is 16 bytes, 010 is 32 bytes, others not used.
// - Single-beat sizes 000..100 are 8,1,2,3,4 bytes; five to seven unused.
// - Three bytes start at offsets 0..5, four bytes at offsets 0..4.
// - Grant qualifies only with no retry now or before and no transfer start.
// - Strap asserted at reset release selects extended mode, otherwise legacy.
// - Everything is driven and sampled on the rising system clock edge.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module split_bus_address_tenure #(
  parameter int ADDR_W = 32
) (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              bus_mode_strap_in,
  input  wire logic [3:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  output logic      [31:0]       reg_rdata_out,
  input  wire logic              xfer_req_in,
  input  wire logic              xfer_write_in,
  input  wire logic              xfer_claim_in,
  input  wire logic              xfer_burst_in,
  input  wire logic [ADDR_W-1:0] xfer_addr_in,
  input  wire logic [5:0]        xfer_len_in,
  output logic                   xfer_ready_out,
  output logic                   xfer_reject_out,
  output logic                   xfer_done_out,
  output logic                   xfer_retry_out,
  input  wire logic              bus_grant_in,
  input  wire logic              transfer_start_in,
  input  wire logic              address_acknowledge_in,
  input  wire logic              address_retry_in,
  input  wire logic              cache_inhibit_attr_in,
  input  wire logic              write_through_attr_in,
  input  wire logic              global_attr_in,
  output logic                   bus_request_out,
  output logic                   transfer_start_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   addr_oe_n_out,
  output logic [3:0]             addr_parity_out,
  output logic [4:0]             transfer_type_out,
  output logic [2:0]             transfer_size_out,
  output logic                   burst_attr_out,
  output logic                   intervention_illegal_out
);

  function automatic logic [3:0] odd_parity(input logic [ADDR_W-1:0] a);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 4; i++) begin
      p[i] = ~^a[i*8 +: 8];
    end
    return p;
  endfunction

  tenure_pkg::tenure_state_t state_ff;
  tenure_pkg::tenure_state_t nxt_state;
  logic [1:0]        phase_ff;
  logic              ext_mode_ff;
  logic              driven_mode_ff;
  logic              stream_en_ff;
  logic              pend_valid_ff;
  logic              pend_write_ff;
  logic              pend_claim_ff;
  logic              pend_burst_ff;
  logic [ADDR_W-1:0] pend_addr_ff;
  logic [2:0]        pend_size_ff;
  logic              act_claim_ff;
  logic              retry_d_ff;
  logic              cur_retried_ff;
  logic              window_ff;
  logic              win_retried_ff;
  logic [7:0]        tenure_cnt_ff;
  logic [2:0]        enc_size;
  logic              enc_legal;
  logic              req_ok;
  logic              accept;
  logic              qualified_grant;
  logic              launch;
  logic              in_tenure;
  logic              nxt_pend_valid;
  logic [4:0]        nxt_type;

  size_encode u_size_encode (
    .burst_in    (xfer_burst_in),
    .ext_mode_in (ext_mode_ff),
    .len_in      (xfer_len_in),
    .ofs_in      (xfer_addr_in[2:0]),
    .size_out    (enc_size),
    .legal_out   (enc_legal)
  );

  assign req_ok = enc_legal && !(xfer_claim_in && (xfer_write_in || !xfer_burst_in));
  assign accept = xfer_req_in && xfer_ready_out && req_ok;
  assign in_tenure = (state_ff == tenure_pkg::ST_TENURE);

  assign qualified_grant = bus_grant_in && !address_retry_in && !retry_d_ff &&
                           !transfer_start_out && !transfer_start_in;

  // launch in the acknowledge cycle when streaming
  assign launch = pend_valid_ff && qualified_grant && (!in_tenure ||
                  (address_acknowledge_in && ext_mode_ff && stream_en_ff));
  assign nxt_pend_valid = (pend_valid_ff && !launch) || accept;

  assign nxt_type = pend_write_ff ? tenure_pkg::TYPE_WRITE :
                    (pend_claim_ff ? (ext_mode_ff ? tenure_pkg::TYPE_READ_CLAIM : tenure_pkg::TYPE_LEGACY_TOUCH)
                                   : tenure_pkg::TYPE_READ);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tenure_pkg::ST_IDLE,
      tenure_pkg::ST_REQ: begin
        if (launch) begin
          nxt_state = tenure_pkg::ST_TENURE;
        end else if (nxt_pend_valid) begin
          nxt_state = tenure_pkg::ST_REQ;
        end else begin
          nxt_state = tenure_pkg::ST_IDLE;
        end
      end
      tenure_pkg::ST_TENURE: begin
        if (launch) begin
          nxt_state = tenure_pkg::ST_TENURE;
        end else if (address_acknowledge_in) begin
          nxt_state = nxt_pend_valid ? tenure_pkg::ST_REQ : tenure_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = tenure_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= tenure_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      phase_ff       <= tenure_pkg::PHASE_MODE;
      ext_mode_ff    <= 1'b0;
      driven_mode_ff <= 1'b0;
    end else begin
      if (phase_ff == tenure_pkg::PHASE_MODE) begin
        ext_mode_ff <= bus_mode_strap_in;
        phase_ff    <= tenure_pkg::PHASE_DRIVEN;
      end else if (phase_ff == tenure_pkg::PHASE_DRIVEN) begin
        driven_mode_ff <= bus_mode_strap_in && ext_mode_ff;
        phase_ff       <= tenure_pkg::PHASE_DONE;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pend_valid_ff   <= 1'b0;
      pend_write_ff   <= 1'b0;
      pend_claim_ff   <= 1'b0;
      pend_burst_ff   <= 1'b0;
      pend_addr_ff    <= '0;
      pend_size_ff    <= tenure_pkg::SZ_8B;
      xfer_ready_out  <= 1'b0;
      xfer_reject_out <= 1'b0;
    end else begin
      pend_valid_ff   <= nxt_pend_valid;
      xfer_ready_out  <= !nxt_pend_valid && (phase_ff == tenure_pkg::PHASE_DONE);
      xfer_reject_out <= xfer_req_in && xfer_ready_out && !req_ok;
      if (accept) begin
        pend_write_ff <= xfer_write_in;
        pend_claim_ff <= xfer_claim_in;
        pend_burst_ff <= xfer_burst_in;
        pend_addr_ff  <= xfer_addr_in;
        pend_size_ff  <= enc_size;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bus_request_out <= 1'b0;
    end else begin
      bus_request_out <= pend_valid_ff && !launch;
    end
  end

  // one start, address held to acknowledge
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      transfer_start_out <= 1'b0;
      addr_out           <= '0;
      addr_parity_out    <= 4'hF;
      transfer_type_out  <= tenure_pkg::TYPE_READ;
      transfer_size_out  <= tenure_pkg::SZ_8B;
      burst_attr_out     <= 1'b0;
      act_claim_ff       <= 1'b0;
      addr_oe_n_out      <= 1'b1;
    end else begin
      transfer_start_out <= launch;
      addr_oe_n_out      <= !(launch || (in_tenure && !address_acknowledge_in) || driven_mode_ff);
      if (launch) begin
        addr_out          <= pend_addr_ff;
        addr_parity_out   <= odd_parity(pend_addr_ff);
        transfer_type_out <= nxt_type;
        transfer_size_out <= pend_size_ff;
        burst_attr_out    <= pend_burst_ff;
        act_claim_ff      <= pend_claim_ff;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      retry_d_ff     <= 1'b0;
      cur_retried_ff <= 1'b0;
      window_ff      <= 1'b0;
      win_retried_ff <= 1'b0;
      xfer_done_out  <= 1'b0;
      xfer_retry_out <= 1'b0;
      tenure_cnt_ff  <= 8'h00;
    end else begin
      retry_d_ff <= address_retry_in;
      window_ff  <= in_tenure && address_acknowledge_in;
      if (launch) begin
        cur_retried_ff <= 1'b0;
      end else if (in_tenure && address_retry_in) begin
        cur_retried_ff <= 1'b1;
      end
      if (in_tenure && address_acknowledge_in) begin
        win_retried_ff <= cur_retried_ff || address_retry_in;
        tenure_cnt_ff  <= tenure_cnt_ff + 8'h01;
      end
      xfer_retry_out <= window_ff && (win_retried_ff || address_retry_in);
      xfer_done_out  <= window_ff && !(win_retried_ff || address_retry_in);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      intervention_illegal_out <= 1'b0;
    end else begin
      intervention_illegal_out <= ext_mode_ff && transfer_start_in && global_attr_in &&
                                  (cache_inhibit_attr_in || write_through_attr_in);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      stream_en_ff  <= tenure_pkg::CTRL_STREAM_RESET;
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      if (reg_write_in && reg_addr_in == tenure_pkg::REG_CTRL_OFS) begin
        stream_en_ff <= reg_wdata_in[tenure_pkg::CTRL_STREAM_BIT];
      end
      reg_rdata_out <= 32'h0000_0000;
      if (reg_read_in) begin
        case (reg_addr_in)
          tenure_pkg::REG_MEMSUB_OFS: begin
            reg_rdata_out[tenure_pkg::MEMSUB_EXT_BIT] <= ext_mode_ff;
            reg_rdata_out[tenure_pkg::MEMSUB_DRIVEN_BIT] <= driven_mode_ff;
          end
          tenure_pkg::REG_CTRL_OFS: begin
            reg_rdata_out[tenure_pkg::CTRL_STREAM_BIT] <= stream_en_ff;
          end
          tenure_pkg::REG_STAT_OFS: begin
            reg_rdata_out[tenure_pkg::STAT_BUSY_BIT] <= in_tenure;
            reg_rdata_out[tenure_pkg::STAT_PEND_BIT] <= pend_valid_ff;
            reg_rdata_out[tenure_pkg::STAT_CNT_LSB +: 8] <= tenure_cnt_ff;
          end
          default: begin
            reg_rdata_out <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_stream_ack;
    in_tenure && address_acknowledge_in && pend_valid_ff && qualified_grant && ext_mode_ff && stream_en_ff;
  endsequence

  sequence s_window_retry;
    window_ff && address_retry_in;
  endsequence

  AST_GRANT_BEFORE_START: assert property (
    transfer_start_out |-> $past(bus_grant_in) && !$past(address_retry_in) &&
                           !$past(address_retry_in, 2) && !$past(transfer_start_in))
    else $error("Start issued without a qualified grant.");

  AST_REQUEST_WAITS: assert property (
    (pend_valid_ff && !launch) |=> bus_request_out)
    else $error("Pending transfer without bus request.");

  AST_PARKED_NO_REQUEST: assert property (
    launch |=> transfer_start_out && !bus_request_out)
    else $error("Parked launch raised a request or missed the start.");

  AST_DRIVEN_NEEDS_EXT: assert property (
    driven_mode_ff |-> ext_mode_ff)
    else $error("Address-driven mode active in legacy mode.");

  AST_DRIVEN_READBACK: assert property (
    (reg_read_in && reg_addr_in == tenure_pkg::REG_MEMSUB_OFS) |=>
      reg_rdata_out[tenure_pkg::MEMSUB_DRIVEN_BIT] == $past(driven_mode_ff))
    else $error("Address-driven bit reads back wrong.");

  AST_STREAM_NO_GAP: assert property (
    s_stream_ack |=> transfer_start_out ##1 !transfer_start_out)
    else $error("Streaming tenure did not follow the acknowledge.");

  AST_CLAIM_TYPE: assert property (
    (transfer_start_out && act_claim_ff) |->
      transfer_type_out == (ext_mode_ff ? tenure_pkg::TYPE_READ_CLAIM : tenure_pkg::TYPE_LEGACY_TOUCH))
    else $error("Touch-for-store read has the wrong type.");

  AST_BURST_SIZE: assert property (
    (transfer_start_out && burst_attr_out) |->
      (transfer_size_out == tenure_pkg::BURST_2DW || transfer_size_out == tenure_pkg::BURST_4DW))
    else $error("Burst driven with an unused size code.");

  AST_SINGLE_SIZE: assert property (
    (transfer_start_out && !burst_attr_out) |-> transfer_size_out <= tenure_pkg::SZ_4B)
    else $error("Single beat driven with an unused size code.");

  AST_PARITY: assert property (
    transfer_start_out |-> addr_parity_out == odd_parity(addr_out))
    else $error("Address parity does not match the address.");

  AST_WINDOW_RETRY: assert property (
    s_window_retry |=> xfer_retry_out && !xfer_done_out)
    else $error("Retry in the window was not reported.");

endmodule // split_bus_address_tenure
`default_nettype wire

// [tb/arbiter_model.sv]
`timescale 1ns/10ps
`default_nettype none
module arbiter_model (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       bus_request_in,
  input  wire logic       start_in,
  input  wire logic       park_in,
  input  wire logic [1:0] delay_in,
  input  wire logic       retry_cmd_in,
  output logic            bus_grant_out,
  output logic            ack_out,
  output logic            retry_out
);
  logic [1:0] wait_ff;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wait_ff   <= 2'h0;
      ack_out   <= 1'b0;
      retry_out <= 1'b0;
    end else begin
      wait_ff   <= start_in ? delay_in : ((wait_ff != 2'h0) ? wait_ff - 2'h1 : 2'h0);
      ack_out   <= (start_in && delay_in == 2'h0) || wait_ff == 2'h1;
      retry_out <= retry_cmd_in && ack_out;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bus_grant_out <= 1'b0;
    end else begin
      bus_grant_out <= (park_in || bus_request_in) && !(start_in && delay_in != 2'h0) && wait_ff < 2'h2;
    end
  end
endmodule // arbiter_model
`default_nettype wire

// [tb/split_bus_address_tenure_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module split_bus_address_tenure_tb;
  typedef struct packed {
    logic [31:0] addr;
    logic [4:0]  ttype;
    logic [2:0]  size;
    logic        burst;
  } exp_t;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        bus_mode_strap_in = 1'b1;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_write_in = 1'b0;
  logic        reg_read_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic        xfer_req_in = 1'b0;
  logic        xfer_write_in = 1'b0;
  logic        xfer_claim_in = 1'b0;
  logic        xfer_burst_in = 1'b0;
  logic [31:0] xfer_addr_in = 32'h0;
  logic [5:0]  xfer_len_in = 6'h0;
  logic        xfer_ready_out, xfer_reject_out, xfer_done_out, xfer_retry_out;
  logic        bus_grant_in, address_acknowledge_in, address_retry_in;
  logic        transfer_start_in = 1'b0;
  logic        cache_inhibit_attr_in = 1'b0;
  logic        write_through_attr_in = 1'b0;
  logic        global_attr_in = 1'b0;
  logic        bus_request_out, transfer_start_out, addr_oe_n_out, burst_attr_out, intervention_illegal_out;
  logic [31:0] addr_out;
  logic [3:0]  addr_parity_out;
  logic [4:0]  transfer_type_out;
  logic [2:0]  transfer_size_out;
  logic        park = 1'b1;
  logic [1:0]  delay = 2'h0;
  logic        retry_cmd = 1'b0;
  logic [31:0] seed = 32'h8;
  logic        ext, drv, saw_req;
  int          n_errors, check_count, cyc, t, last, gap, n_start, n_end, n_sub, n_rty, n_int, k, m;
  exp_t        expq[$];
  exp_t        ex;
  logic [15:0] tab[16] = '{16'h0171, 16'h0260, 16'h0350, 16'h0440, 16'h0800, 16'h1004, 16'h2004, 16'h2006,
                           16'h0360, 16'h0450, 16'h0810, 16'h0270, 16'h0500, 16'h0802, 16'h2007, 16'h2104};

  always #5 clock_in = ~clock_in;

  split_bus_address_tenure DUT (
    .clock_in, .rst_in, .bus_mode_strap_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
    .reg_rdata_out, .xfer_req_in, .xfer_write_in, .xfer_claim_in, .xfer_burst_in, .xfer_addr_in, .xfer_len_in,
    .xfer_ready_out, .xfer_reject_out, .xfer_done_out, .xfer_retry_out, .bus_grant_in, .transfer_start_in,
    .address_acknowledge_in, .address_retry_in, .cache_inhibit_attr_in, .write_through_attr_in, .global_attr_in,
    .bus_request_out, .transfer_start_out, .addr_out, .addr_oe_n_out, .addr_parity_out, .transfer_type_out,
    .transfer_size_out, .burst_attr_out, .intervention_illegal_out);

  arbiter_model arb (
    .clock_in, .rst_in, .bus_request_in(bus_request_out), .start_in(transfer_start_out), .park_in(park),
    .delay_in(delay), .retry_cmd_in(retry_cmd), .bus_grant_out(bus_grant_in), .ack_out(address_acknowledge_in),
    .retry_out(address_retry_in));

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [3:0] par(input logic [31:0] a);
    for (int i = 0; i < 4; i++) par[i] = ~^a[8*i+:8];
  endfunction

  function automatic logic [2:0] sz(input logic [5:0] len, input logic b);
    if (b) return (len == 6'h10) ? 3'h1 : 3'h2;
    return (len == 6'h08) ? 3'h0 : len[2:0];
  endfunction

  // Flags are burst, claim, write from high to low.
  function automatic logic legal(input logic [5:0] len, input logic [2:0] ofs, input logic [2:0] f);
    if (f[1] && (f[0] || !f[2])) return 1'b0;
    if (f[2]) return ofs == 3'h0 && (len == 6'h20 || (len == 6'h10 && ext));
    case (len)
      6'h01: return 1'b1;
      6'h02: return ofs <= 3'h6;
      6'h03: return ofs <= 3'h5;
      6'h04: return ofs <= 3'h4;
      6'h08: return ofs == 3'h0;
      default: return 1'b0;
    endcase
  endfunction

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    @(posedge clock_in);
    check("rdata", reg_rdata_out, exp);
  endtask

  task automatic do_reset(input logic s1, input logic s2);
    rst_in <= 1'b1;
    bus_mode_strap_in <= s1;
    @(posedge clock_in);
    #1;
    check("oe_rst", addr_oe_n_out, 1'b1);
    check("par_rst", addr_parity_out, 4'hF);
    @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    bus_mode_strap_in <= s2;
    repeat (2) @(posedge clock_in);
    ext = s1;
    drv = s1 & s2;
    reg_rd(4'h0, {30'h0, drv, ext});
  endtask

  task automatic submit(input logic [15:0] ent);
    logic ok;
    exp_t e;
    seed = xs(seed);
    ok = legal(ent[13:8], ent[6:4], ent[2:0]);
    e.addr = {seed[31:3], ent[6:4]};
    e.ttype = ent[1] ? (ext ? 5'h0F : 5'h0E) : (ent[0] ? tenure_pkg::TYPE_WRITE : tenure_pkg::TYPE_READ);
    e.size = sz(ent[13:8], ent[2]);
    e.burst = ent[2];
    @(posedge clock_in);
    xfer_req_in <= 1'b1;
    xfer_len_in <= ent[13:8];
    xfer_addr_in <= e.addr;
    {xfer_burst_in, xfer_claim_in, xfer_write_in} <= ent[2:0];
    do @(posedge clock_in); while (xfer_ready_out !== 1'b1);
    xfer_req_in <= 1'b0;
    if (ok) expq.push_back(e);
    n_sub += ok;
    #1;
    check("reject", xfer_reject_out, !ok);
  endtask

  task automatic settle();
    for (int i = 0; i < 60 && n_end != n_sub; i++) @(posedge clock_in);
    #1;
    check("ends", n_end, n_sub);
    check("oe_idle", addr_oe_n_out, !drv);
    @(posedge clock_in);
  endtask

  task automatic pair();
    submit(16'h0800);
    submit(16'h0800);
    settle();
  endtask

  task automatic snoop(input logic [1:0] cw);
    int k0;
    k0 = n_int;
    {cache_inhibit_attr_in, write_through_attr_in} <= cw;
    global_attr_in <= 1'b1;
    transfer_start_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    transfer_start_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    check("intv", n_int - k0, (ext && cw != 2'h0) ? 3 : 0);
    @(posedge clock_in);
  endtask

  task automatic results();
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    if (++cyc == 5000) begin
      n_errors++;
      results();
    end
  end

  // Reference side: every launched tenure is matched in order against the queue.
  always @(posedge clock_in) begin
    t++;
    if (rst_in === 1'b0) begin
      saw_req |= bus_request_out === 1'b1;
      n_end += (xfer_done_out === 1'b1 || xfer_retry_out === 1'b1);
      n_rty += xfer_retry_out === 1'b1;
      n_int += intervention_illegal_out === 1'b1;
      if (transfer_start_out === 1'b1) begin
        ex = expq.pop_front();
        gap = t - last;
        last = t;
        n_start++;
        check("addr", addr_out, ex.addr);
        check("par", addr_parity_out, par(ex.addr));
        check("type", transfer_type_out, ex.ttype);
        check("size", transfer_size_out, ex.size);
        check("burst", burst_attr_out, ex.burst);
        check("oe_n", addr_oe_n_out, 1'b0);
      end
    end
  end

  initial begin
    do_reset(1'b1, 1'b1);
    reg_wr(4'h0, 32'h0);
    reg_rd(4'h0, 32'h3);
    reg_rd(4'h4, 32'h1);
    reg_rd(4'hC, 32'h0);
    for (m = 0; m < 2; m++) begin
      if (m == 1) do_reset(1'b0, 1'b1);
      foreach (tab[i]) submit(tab[i]);
      settle();
      for (k = 0; k < 4; k++) snoop(k[1:0]);
      pair();
      check("gap", ext ? gap : 32'(gap >= 3), ext ? 2 : 1);
    end
    do_reset(1'b1, 1'b0);
    m = n_start;
    reg_wr(4'h4, 32'h0);
    reg_rd(4'h4, 32'h0);
    pair();
    check("gap_off", 32'(gap >= 3), 1);
    reg_wr(4'h4, 32'h1);
    delay <= 2'h1;
    pair();
    check("gap_dly", gap, 3);
    delay <= 2'h0;
    retry_cmd <= 1'b1;
    k = n_rty;
    pair();
    check("retry", n_rty - k, 2);
    retry_cmd <= 1'b0;
    park <= 1'b0;
    saw_req = 1'b0;
    submit(16'h0800);
    settle();
    check("req", saw_req, 1'b1);
    park <= 1'b1;
    saw_req = 1'b0;
    submit(16'h0800);
    settle();
    check("no_req", saw_req, 1'b0);
    transfer_start_in <= 1'b1;
    submit(16'h0800);
    k = n_start;
    repeat (3) @(posedge clock_in);
    check("blocked", n_start, k);
    transfer_start_in <= 1'b0;
    settle();
    reg_rd(4'h8, {16'h0, 8'(n_start - m), 8'h00});
    results();
  end
endmodule // split_bus_address_tenure_tb
`default_nettype wire
